// *** core/iefc_edge_det.sv ***
// Selectable edge detector for the synchronised external pin.
// Assumes pin_level is already in the sys_clk domain.
`timescale 1ns/1ps
module iefc_edge_det (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Level and edge choice (1 = rising)
  input  wire logic pin_level,
  input  wire logic edge_rising,
  // One-cycle event
  output logic      edge_pulse
);

  logic       prev_ff;
  logic       nxt_prev;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic       armed;
  logic       pulse;

  // Sync chain leaves reset at zero, so a pin idling high would look
  // like a rising edge; edges count only once real samples fill it
  always_comb begin
    nxt_prev   = pin_level;
    armed      = (settle_ff == 2'h3);
    nxt_settle = armed ? settle_ff : settle_ff + 2'h1;
    if (edge_rising) begin
      pulse = pin_level & ~prev_ff & armed; // R21
    end else begin
      pulse = ~pin_level & prev_ff & armed; // R21
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff   <= 1'b0;
      settle_ff <= 2'h0;
    end else begin
      prev_ff   <= nxt_prev;
      settle_ff <= nxt_settle;
    end
  end

  assign edge_pulse = pulse;

endmodule : iefc_edge_det

// *** core/iefc_pkg.sv ***
// Constants for the interrupt enable and flag register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package iefc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CORE_CTRL  = 5'h00;
  localparam logic [4:0] OFS_PER_EN1    = 5'h04;
  localparam logic [4:0] OFS_PER_EN2    = 5'h08;
  localparam logic [4:0] OFS_PER_EN3    = 5'h0c;
  localparam logic [4:0] OFS_PER_PEND1  = 5'h10;
  localparam logic [4:0] OFS_PER_PEND2  = 5'h14;
  localparam logic [4:0] OFS_PER_PEND3  = 5'h18;

  // Core control field positions
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_TMR0_EN     = 5;
  localparam int BIT_EXT_EN      = 4;
  localparam int BIT_PCHG_EN     = 3;
  localparam int BIT_TMR0_FLAG   = 2;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_PCHG_FLAG   = 0;

  // Peripheral bank one / two / three field positions
  localparam int BIT_T1_GATE     = 7;
  localparam int BIT_ADC_DONE    = 6;
  localparam int BIT_SER_RX      = 5;
  localparam int BIT_SER_TX      = 4;
  localparam int BIT_T2_MATCH    = 1;
  localparam int BIT_T1_OVF      = 0;
  localparam int BIT_CMP_ONE     = 5;
  localparam int BIT_PWM_CH3     = 6;
  localparam int BIT_PWM_CH2     = 5;
  localparam int BIT_PWM_CH1     = 4;

  // Implemented-bit masks; other positions read zero, except core bit 0, the read-only pin-change summary
  localparam logic [7:0] MASK_CORE_RW  = 8'hfe;
  localparam logic [7:0] MASK_BANK1    = 8'hf3;
  localparam logic [7:0] MASK_BANK1_NS = 8'hc3;
  localparam logic [7:0] MASK_BANK2    = 8'h20;
  localparam logic [7:0] MASK_BANK3    = 8'h70;

  // Reset values
  localparam logic [7:0] RST_REG8      = 8'h00;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

  // Vector the core jumps to on an accepted request
  localparam logic [15:0] IRQ_VECTOR   = 16'h0004;

  // Register select from a byte address
  typedef enum logic [7:0] {
    SEL_NONE  = 8'h00,
    SEL_CORE  = 8'h01,
    SEL_EN1   = 8'h02,
    SEL_EN2   = 8'h04,
    SEL_EN3   = 8'h08,
    SEL_PEND1 = 8'h10,
    SEL_PEND2 = 8'h20,
    SEL_PEND3 = 8'h40
  } iefc_sel_t;

  function automatic iefc_sel_t iefc_decode(input logic [4:0] addr);
    case (addr)
      OFS_CORE_CTRL: iefc_decode = SEL_CORE;
      OFS_PER_EN1:   iefc_decode = SEL_EN1;
      OFS_PER_EN2:   iefc_decode = SEL_EN2;
      OFS_PER_EN3:   iefc_decode = SEL_EN3;
      OFS_PER_PEND1: iefc_decode = SEL_PEND1;
      OFS_PER_PEND2: iefc_decode = SEL_PEND2;
      OFS_PER_PEND3: iefc_decode = SEL_PEND3;
      default:       iefc_decode = SEL_NONE;
    endcase
  endfunction : iefc_decode

endpackage : iefc_pkg

// *** core/iefc_sync2.sv ***
// Two-flop synchroniser for a level from outside the sys_clk domain.
// Assumes the input holds long enough to be seen by two edges.
`timescale 1ns/1ps
module iefc_sync2 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Level in, level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : iefc_sync2

// *** core/iefc_top.sv ***
// Interrupt enable and flag register bank with Avalon-MM slave port.
// Assumes event pulses are one sys_clk cycle wide and synchronous.
//
// Functional notes
// R1 - Global enable bit 7 passes all enabled requests; zero blocks every request.
// R2 - Group enable bit 6 must be set for peripheral-bank sources to request.
// R3 - Pending flags set on their event regardless of any enable bit.
// R4 - Software should clear a stale flag before setting its enable.
// R5 - Control bits 5, 4, 3 enable timer0, external pin and pin-change sources.
// R6 - Control bit 2 sets when timer0 count overflows.
// R7 - Control bit 1 sets on a qualifying external pin edge.
// R8 - Control bit 0 reads one while any individual pin-change flag is set.
// R9 - Bit 0 is read-only, ignores writes; other control bits read/write.
// R10 - Bank one enables: gate bit 7, ADC bit 6, timer2 bit 1, timer1 bit 0.
// R11 - Serial enables at bits 5 and 4 exist only with the serial port.
// R12 - Unimplemented bits ignore writes and read zero.
// R13 - Bank two enable implements only bit 5, comparator one.
// R14 - Bank three enables PWM channels 3, 2, 1 at bits 6, 5, 4.
// R15 - Bank one flags share positions with bank one enables; one means pending.
// R16 - Bank two flag implements only bit 5, paired with its enable.
// R17 - Bank three flags are read-only copies of the PWM modules' flags.
// R18 - Every implemented bit resets to zero on any reset.
// R19 - Accepted request clears global enable; core jumps to vector 0004h.
// R20 - Return from interrupt sets the global enable again.
// R21 - External event is rising edge when select is one, else falling.
// R22 - Request when global enable and any enabled pending source qualifies.
// R23 - Event pulses are one cycle; set beats a same-cycle clear.
`timescale 1ns/1ps
module iefc_top
  import iefc_pkg::*;
#(
  parameter bit SERIAL_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Core-register event sources
  input  wire logic        timer0_overflow_evt,
  input  wire logic        ext_pin,
  input  wire logic        ext_edge_select,
  input  wire logic        pin_change_any,
  // Peripheral event pulses
  input  wire logic        timer1_gate_evt,
  input  wire logic        adc_done_evt,
  input  wire logic        serial_rx_evt,
  input  wire logic        serial_tx_evt,
  input  wire logic        timer2_match_evt,
  input  wire logic        timer1_overflow_evt,
  input  wire logic        comparator_one_evt,
  // PWM module flag levels, channels 3..1 in bits 2..0
  input  wire logic [2:0]  pwm_flag_in,
  // Processor core handshake
  input  wire logic        irq_taken,
  input  wire logic        return_from_irq,
  output logic             irq_req,
  output logic [15:0]      irq_vector
);

  // Bus state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } iefc_bus_state_t;

  iefc_bus_state_t state_ff;
  iefc_bus_state_t nxt_state;
  logic            wait_ff;
  logic            nxt_wait;
  logic [31:0]     rdata_ff;
  logic [31:0]     nxt_rdata;

  // Register state
  logic [7:0] core_irq_control_ff;
  logic [7:0] nxt_core_irq_control;
  logic [7:0] peripheral_enable_one_ff;
  logic [7:0] nxt_peripheral_enable_one;
  logic [7:0] peripheral_enable_two_ff;
  logic [7:0] nxt_peripheral_enable_two;
  logic [7:0] peripheral_enable_three_ff;
  logic [7:0] nxt_peripheral_enable_three;
  logic [7:0] peripheral_pending_one_ff;
  logic [7:0] nxt_peripheral_pending_one;
  logic [7:0] peripheral_pending_two_ff;
  logic [7:0] nxt_peripheral_pending_two;
  logic [7:0] peripheral_pending_three_ff;
  logic [7:0] nxt_peripheral_pending_three;
  logic       pin_change_summary_ff;
  logic       nxt_pin_change_summary;

  // Request output
  logic        irq_req_ff;
  logic        nxt_irq_req;
  logic [15:0] vector_ff;

  // Decode and event wiring
  iefc_sel_t  sel;
  logic       wr_ok;
  logic [7:0] wbyte;
  logic [7:0] bank1_mask;
  logic [7:0] bank1_set;
  logic [7:0] bank2_set;
  logic [7:0] pwm_copy;
  logic [7:0] core_view;
  logic       ext_pin_sync;
  logic       ext_edge_sel_sync;
  logic       ext_pin_evt;
  logic       core_pending;
  logic       periph_pending;

  // External pin and its edge select come from outside the clock domain
  iefc_sync2 u_sync_pin (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (ext_pin),
    .sync_out (ext_pin_sync)
  );

  iefc_sync2 u_sync_edge_sel (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (ext_edge_select),
    .sync_out (ext_edge_sel_sync)
  );

  iefc_edge_det u_edge (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .pin_level   (ext_pin_sync),
    .edge_rising (ext_edge_sel_sync),
    .edge_pulse  (ext_pin_evt)
  );

  // Bus decode; a write lands only at the edge where waitrequest is low
  always_comb begin
    sel   = iefc_decode(avs_address);
    wr_ok = (state_ff == ST_ACK) & avs_write & avs_byteenable[0];
    wbyte = avs_writedata[7:0];
  end

  // Serial bits vanish entirely on the variant without the serial port
  always_comb begin
    bank1_mask = SERIAL_PRESENT ? MASK_BANK1 : MASK_BANK1_NS; // R11
  end

  // Event vectors at their register positions
  always_comb begin
    bank1_set = 8'h00;
    bank1_set[BIT_T1_GATE]  = timer1_gate_evt;
    bank1_set[BIT_ADC_DONE] = adc_done_evt;
    bank1_set[BIT_SER_RX]   = serial_rx_evt;
    bank1_set[BIT_SER_TX]   = serial_tx_evt;
    bank1_set[BIT_T2_MATCH] = timer2_match_evt;
    bank1_set[BIT_T1_OVF]   = timer1_overflow_evt;
    bank2_set = 8'h00;
    bank2_set[BIT_CMP_ONE]  = comparator_one_evt;
    pwm_copy = 8'h00;
    pwm_copy[BIT_PWM_CH3]   = pwm_flag_in[2];
    pwm_copy[BIT_PWM_CH2]   = pwm_flag_in[1];
    pwm_copy[BIT_PWM_CH1]   = pwm_flag_in[0];
  end

  // Core control register
  always_comb begin
    nxt_core_irq_control = core_irq_control_ff;
    if (wr_ok && sel == SEL_CORE) begin
      nxt_core_irq_control = wbyte & MASK_CORE_RW; // R9 R5
    end
    // Hardware sets win over a same-cycle software clear
    if (timer0_overflow_evt) begin
      nxt_core_irq_control[BIT_TMR0_FLAG] = 1'b1; // R6 R3 R23
    end
    if (ext_pin_evt) begin
      nxt_core_irq_control[BIT_EXT_FLAG] = 1'b1; // R7 R3 R21
    end
    // Core handshake has the last word on the global enable
    if (return_from_irq) begin
      nxt_core_irq_control[BIT_GLOBAL_EN] = 1'b1; // R20
    end
    if (irq_taken && core_irq_control_ff[BIT_GLOBAL_EN]) begin
      nxt_core_irq_control[BIT_GLOBAL_EN] = 1'b0; // R19
    end
    nxt_core_irq_control[BIT_PCHG_FLAG] = 1'b0; // R12
  end

  // Summary flag follows the pin-change flags, never the bus
  always_comb begin
    nxt_pin_change_summary = pin_change_any; // R8 R9
  end

  // Enable registers
  always_comb begin
    nxt_peripheral_enable_one   = peripheral_enable_one_ff;
    nxt_peripheral_enable_two   = peripheral_enable_two_ff;
    nxt_peripheral_enable_three = peripheral_enable_three_ff;
    if (wr_ok && sel == SEL_EN1) begin
      nxt_peripheral_enable_one = wbyte & bank1_mask; // R10 R11 R12
    end
    if (wr_ok && sel == SEL_EN2) begin
      nxt_peripheral_enable_two = wbyte & MASK_BANK2; // R13 R12
    end
    if (wr_ok && sel == SEL_EN3) begin
      nxt_peripheral_enable_three = wbyte & MASK_BANK3; // R14 R12
    end
  end

  // Pending registers; set wins over a same-cycle clear
  always_comb begin
    nxt_peripheral_pending_one = peripheral_pending_one_ff;
    nxt_peripheral_pending_two = peripheral_pending_two_ff;
    if (wr_ok && sel == SEL_PEND1) begin
      nxt_peripheral_pending_one = wbyte; // R15
    end
    if (wr_ok && sel == SEL_PEND2) begin
      nxt_peripheral_pending_two = wbyte; // R16
    end
    nxt_peripheral_pending_one = (nxt_peripheral_pending_one | bank1_set)
                                 & bank1_mask; // R3 R23 R12
    nxt_peripheral_pending_two = (nxt_peripheral_pending_two | bank2_set)
                                 & MASK_BANK2; // R3 R23 R12
    // Copies only; software clears these inside each PWM module
    nxt_peripheral_pending_three = pwm_copy & MASK_BANK3; // R17
  end

  // Request to the core, registered so the output is glitch-free
  always_comb begin
    core_pending = (core_irq_control_ff[BIT_TMR0_EN] & core_irq_control_ff[BIT_TMR0_FLAG])
                 | (core_irq_control_ff[BIT_EXT_EN] & core_irq_control_ff[BIT_EXT_FLAG])
                 | (core_irq_control_ff[BIT_PCHG_EN] & pin_change_summary_ff); // R5
    periph_pending = |(peripheral_enable_one_ff & peripheral_pending_one_ff)
                   | |(peripheral_enable_two_ff & peripheral_pending_two_ff)
                   | |(peripheral_enable_three_ff & peripheral_pending_three_ff);
    nxt_irq_req = core_irq_control_ff[BIT_GLOBAL_EN] // R1
                & (core_pending
                   | (core_irq_control_ff[BIT_PERIPH_EN] & periph_pending)); // R2 R22
  end

  // Read view of the control register with the live summary bit
  always_comb begin
    core_view = core_irq_control_ff;
    core_view[BIT_PCHG_FLAG] = pin_change_summary_ff; // R8
  end

  // Bus state machine: one wait cycle, then the answer
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = ST_ACK;
          nxt_wait  = 1'b0;
          nxt_rdata = RST_RDATA;
          if (avs_read) begin
            case (sel)
              SEL_CORE:  nxt_rdata[7:0] = core_view;
              SEL_EN1:   nxt_rdata[7:0] = peripheral_enable_one_ff;
              SEL_EN2:   nxt_rdata[7:0] = peripheral_enable_two_ff;
              SEL_EN3:   nxt_rdata[7:0] = peripheral_enable_three_ff;
              SEL_PEND1: nxt_rdata[7:0] = peripheral_pending_one_ff;
              SEL_PEND2: nxt_rdata[7:0] = peripheral_pending_two_ff;
              SEL_PEND3: nxt_rdata[7:0] = peripheral_pending_three_ff;
              default:   nxt_rdata[7:0] = RST_REG8; // R12
            endcase
          end
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
        nxt_wait  = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_wait  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= RST_RDATA;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_irq_control_ff         <= RST_REG8; // R18
      peripheral_enable_one_ff    <= RST_REG8; // R18
      peripheral_enable_two_ff    <= RST_REG8; // R18
      peripheral_enable_three_ff  <= RST_REG8; // R18
      peripheral_pending_one_ff   <= RST_REG8; // R18
      peripheral_pending_two_ff   <= RST_REG8; // R18
      peripheral_pending_three_ff <= RST_REG8; // R18
      pin_change_summary_ff       <= 1'b0;
    end else begin
      core_irq_control_ff         <= nxt_core_irq_control;
      peripheral_enable_one_ff    <= nxt_peripheral_enable_one;
      peripheral_enable_two_ff    <= nxt_peripheral_enable_two;
      peripheral_enable_three_ff  <= nxt_peripheral_enable_three;
      peripheral_pending_one_ff   <= nxt_peripheral_pending_one;
      peripheral_pending_two_ff   <= nxt_peripheral_pending_two;
      peripheral_pending_three_ff <= nxt_peripheral_pending_three;
      pin_change_summary_ff       <= nxt_pin_change_summary;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_ff <= 1'b0;
      vector_ff  <= 16'h0000;
    end else begin
      irq_req_ff <= nxt_irq_req;
      vector_ff  <= IRQ_VECTOR; // R19
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq_req         = irq_req_ff;
  assign irq_vector      = vector_ff;

endmodule : iefc_top

// *** test/iefc_chk_props.sv ***
// Port-level checks for the interrupt enable and flag register bank.
// Assumes it is bound onto iefc_top and sees only that module's ports.
`timescale 1ns/1ps
module iefc_chk
  import iefc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sources and core
  input wire logic [2:0]  pwm_flag_in,
  input wire logic        irq_taken,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence take_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_hole_s;
    take_s ##0 avs_read && (avs_address[1:0] != 2'h0 || avs_address > 5'h18);
  endsequence
  sequence rd_pwm_s;
    take_s ##0 avs_read && avs_address == 5'h18 && $stable(pwm_flag_in);
  endsequence

  one_wait_a: assert property (take_s |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_hold_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  hole_zero_a: assert property (rd_hole_s |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pwm_copy_a: assert property (rd_pwm_s |=>
    avs_readdata[7:0] == {1'b0, $past(pwm_flag_in), 4'h0})
    else $error("pwm pending copy wrong");
  taken_drop_a: assert property (irq_taken |-> ##2 !irq_req)
    else $error("request stays after core took it");
  vector_fix_a: assert property ($past(arst_n) |-> irq_vector == 16'h0004)
    else $error("vector address wrong");
endmodule : iefc_chk

bind iefc_top iefc_chk u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm_flag_in(pwm_flag_in), .irq_taken(irq_taken), .irq_req(irq_req), .irq_vector(irq_vector)
);

// *** test/iefc_partner.sv ***
// Model of the peripherals and the processor core around the bank.
// Assumes commands from the bench arrive one sys_clk cycle wide.
`timescale 1ns/1ps
module iefc_partner (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Bench control
  input  wire logic [7:0] evt_cmd,
  input  wire logic       take_en,
  input  wire logic [3:0] take_wait,
  // Bank side
  input  wire logic       irq_req,
  output logic [7:0]      evt_pulse,
  output logic            irq_taken
);
  logic [7:0] evt_ff, nxt_evt;
  logic [3:0] cnt_ff, nxt_cnt;
  logic       take_ff, nxt_take, busy_ff, nxt_busy;

  always_comb begin
    nxt_evt  = evt_cmd;
    nxt_take = irq_req && take_en && !busy_ff && cnt_ff == take_wait;
    nxt_cnt  = (irq_req && take_en && !busy_ff) ? cnt_ff + 4'h1 : 4'h0;
    // Take once per request so a slow core never double-acknowledges
    nxt_busy = irq_req && (busy_ff || nxt_take);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_ff  <= 8'h00;
      cnt_ff  <= 4'h0;
      take_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      evt_ff  <= nxt_evt;
      cnt_ff  <= nxt_cnt;
      take_ff <= nxt_take;
      busy_ff <= nxt_busy;
    end
  end

  assign evt_pulse = evt_ff;
  assign irq_taken = take_ff;
endmodule : iefc_partner

// *** test/tb.sv ***
// Self-checking bench for the interrupt enable and flag register bank.
// Assumes the partner model supplies event pulses and core acknowledges.
`timescale 1ns/1ps
module tb;
  import iefc_pkg::*;
  logic        sys_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, take_wait;
  logic        ext_pin, ext_edge_select, pin_change_any, take_en, irq_taken;
  logic        return_from_irq, irq_req;
  logic [2:0]  pwm_flag_in;
  logic [7:0]  evt_cmd, evt;
  logic [15:0] irq_vector;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [4:0]  ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
  logic [7:0]  msk [7] = '{8'hfe, 8'hf3, 8'h20, 8'h70, 8'hf3, 8'h20, 8'h00};
  // Per step: [3] edge select, [2] pin level, [1:0] expected control bits
  logic [3:0]  pin_tab [4] = '{4'h4, 4'h2, 4'he, 4'h8};

  iefc_top uut (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer0_overflow_evt(evt[7]), .ext_pin,
    .ext_edge_select, .pin_change_any, .timer1_gate_evt(evt[6]), .adc_done_evt(evt[5]),
    .serial_rx_evt(evt[4]), .serial_tx_evt(evt[3]), .timer2_match_evt(evt[2]),
    .timer1_overflow_evt(evt[1]), .comparator_one_evt(evt[0]), .pwm_flag_in, .irq_taken,
    .return_from_irq, .irq_req, .irq_vector);
  iefc_partner u_far (.sys_clk, .arst_n, .evt_cmd, .take_en, .take_wait, .irq_req,
    .evt_pulse(evt), .irq_taken);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read       <= !is_wr;
    avs_write      <= is_wr;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk($sformatf("reg %h", a), q, {24'h0, exp});
  endtask : rd

  task automatic req_is(input logic exp);
    // Sampled at the edge, so the caller's next stimulus stays on an edge
    repeat (3) @(posedge sys_clk);
    chk("irq_req", {31'h0, irq_req}, {31'h0, exp});
  endtask : req_is

  task automatic fire(input logic [7:0] m);
    @(posedge sys_clk);
    evt_cmd <= m;
    @(posedge sys_clk);
    evt_cmd <= 8'h00;
  endtask : fire

  task automatic reset_chk();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00);
  endtask : reset_chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {ext_pin, ext_edge_select, pin_change_any, pwm_flag_in, evt_cmd} = '0;
    {take_en, take_wait, return_from_irq} = '0;
    reset_chk();
    for (int i = 0; i < 7; i++) begin
      wr(ofs[i], 8'hff);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
      rd(ofs[i], 8'h00);
    end
    bus(1'b1, 5'h08, 8'hff, 4'h0);
    rd(5'h08, 8'h00);
    wr(5'h1c, 8'hff);
    rd(5'h1c, 8'h00);
    rd(5'h02, 8'h00);
    fire(8'hff);
    rd(5'h00, 8'h04);
    rd(5'h10, 8'hf3);
    rd(5'h14, 8'h20);
    wr(5'h04, 8'h01);
    wr(5'h00, 8'h80);
    req_is(1'b0);
    wr(5'h00, 8'hc0);
    req_is(1'b1);
    wr(5'h00, 8'h40);
    req_is(1'b0);
    wr(5'h10, 8'h00);
    wr(5'h14, 8'h00);
    wr(5'h00, 8'ha0);
    fire(8'h80);
    req_is(1'b1);
    // Slow core first, then a prompt one
    take_wait <= 4'h5;
    take_en   <= 1'b1;
    repeat (12) @(posedge sys_clk);
    take_en <= 1'b0;
    #1 chk("irq_req", {31'h0, irq_req}, 32'h0);
    chk("irq_vector", {16'h0, irq_vector}, 32'h0004);
    rd(5'h00, 8'h24);
    @(posedge sys_clk);
    return_from_irq <= 1'b1;
    @(posedge sys_clk);
    return_from_irq <= 1'b0;
    rd(5'h00, 8'ha4);
    take_wait <= 4'h0;
    take_en   <= 1'b1;
    repeat (6) @(posedge sys_clk);
    take_en <= 1'b0;
    rd(5'h00, 8'h24);
    wr(5'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      ext_edge_select <= pin_tab[i][3];
      @(posedge sys_clk);
      ext_pin <= pin_tab[i][2];
      repeat (6) @(posedge sys_clk);
      rd(5'h00, {6'h0, pin_tab[i][1:0]});
      wr(5'h00, 8'h00);
    end
    pin_change_any <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(5'h00, 8'h01);
    wr(5'h00, 8'h00);
    rd(5'h00, 8'h01);
    pin_change_any <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(5'h00, 8'h00);
    pwm_flag_in <= 3'b101;
    repeat (2) @(posedge sys_clk);
    rd(5'h18, 8'h50);
    wr(5'h18, 8'h00);
    rd(5'h18, 8'h50);
    wr(5'h0c, 8'h40);
    wr(5'h00, 8'hc0);
    req_is(1'b1);
    pwm_flag_in <= 3'b000;
    req_is(1'b0);
    reset_chk();
    complete_run();
  end
endmodule : tb
